// *** inc/rdc_pkg.sv ***
// constants, state types and helpers for the reset domain controller
// assumes a single 25 MHz clock and byte-wide serial register access

package rdc_pkg;

	// ------------------------------------------------------------
	// serial slave addresses
	// ------------------------------------------------------------
	localparam logic [6:0] RDC_SID_VSCALE = 7'h12;
	localparam logic [6:0] RDC_SID_CTL1 = 7'h48;
	localparam logic [6:0] RDC_SID_CTL2 = 7'h49;
	localparam logic [6:0] RDC_SID_CTL3 = 7'h4A;

	// ------------------------------------------------------------
	// register offsets on the first control slave
	// ------------------------------------------------------------
	localparam logic [7:0] RDC_OFS_TURNOFF = 8'h22;
	localparam logic [7:0] RDC_OFS_DEVON = 8'h25;
	localparam logic [7:0] RDC_OFS_PSTATE = 8'h27;
	localparam logic [7:0] RDC_OFS_WDT = 8'h2C;
	localparam logic [7:0] RDC_OFS_KPD = 8'h2D;
	localparam logic [7:0] RDC_OFS_FLAG = 8'h3A;
	localparam logic [7:0] RDC_OFS_FLAG_SET = 8'h3B;
	localparam logic [7:0] RDC_OFS_FLAG_CLR = 8'h3C;

	// ------------------------------------------------------------
	// field positions, masks and reset values
	// ------------------------------------------------------------
	localparam int RDC_SWRST_BIT = 6;
	localparam int RDC_DEVICE_TURN_OFF_BIT_BIT = 0;
	localparam int RDC_KPD_STS_BIT = 7;
	localparam logic [7:0] RDC_DEVON_MASK = 8'h41;
	localparam logic [7:0] RDC_WDT_MASK = 8'h7F;
	localparam logic [7:0] RDC_KPD_MASK = 8'h5F;
	localparam logic [7:0] RDC_RST_WDT = 8'h00;
	localparam logic [7:0] RDC_RST_KPD = 8'h00;
	localparam logic [7:0] RDC_RST_FLAG = 8'h00;
	localparam logic [7:0] RDC_RST_CAUSE = 8'h00;

	// domain bit index: 0 backup, 1 config, 2 state, 3 charger
	localparam int RDC_DOM_BACKUP = 0;
	localparam int RDC_DOM_CONFIG = 1;
	localparam int RDC_DOM_STATE = 2;
	localparam int RDC_DOM_CHG = 3;
	localparam logic [3:0] RDC_DOM_ALL = 4'hF;
	localparam logic [3:0] RDC_DOM_NOBCK = 4'hE;
	localparam logic [3:0] RDC_DOM_WARM = 4'hA;
	localparam logic [3:0] RDC_DOM_NONE = 4'h0;

	// event priority index, lowest index wins
	localparam int RDC_EV_OSC = 0;
	localparam int RDC_EV_BAT = 1;
	localparam int RDC_EV_HOT = 2;
	localparam int RDC_EV_WDT = 3;
	localparam int RDC_EV_KEY = 4;
	localparam int RDC_EV_SW = 5;
	localparam int RDC_EV_WARM = 6;
	localparam int RDC_EV_OFF = 7;

	// power group state codes
	localparam logic [1:0] RDC_PS_WAIT = 2'h0;
	localparam logic [1:0] RDC_PS_ACTIVE = 2'h1;
	localparam logic [1:0] RDC_PS_BACKUP = 2'h2;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int RDC_CLK_NS = 40;
	localparam int RDC_SWRST_LOW_NS = 2000;
	localparam int RDC_SWRST_CYC = (RDC_SWRST_LOW_NS + RDC_CLK_NS - 1) /
		RDC_CLK_NS;
	localparam int RDC_CNT_W = $clog2(RDC_SWRST_CYC + 1);
	localparam logic [RDC_CNT_W-1:0] RDC_SW_LAST =
		RDC_CNT_W'(RDC_SWRST_CYC - 1);

	typedef enum logic [3:0] {
		ST_ACTIVE = 4'h1,
		ST_PULSE = 4'h2,
		ST_WAIT = 4'h4,
		ST_BACKUP = 4'h8
	} rdc_state_type;

	typedef enum logic [8:0] {
		I_IDLE = 9'h001,
		I_DEV = 9'h002,
		I_ADEV = 9'h004,
		I_REG = 9'h008,
		I_AREG = 9'h010,
		I_WRD = 9'h020,
		I_AWR = 9'h040,
		I_RDD = 9'h080,
		I_RACK = 9'h100
	} rdc_i2c_type;

	function automatic logic rdc_sid_ok(input logic [6:0] s);
		return (s == RDC_SID_VSCALE) || (s == RDC_SID_CTL1) ||
			(s == RDC_SID_CTL2) || (s == RDC_SID_CTL3);
	endfunction

	function automatic logic [7:0] rdc_first(input logic [7:0] r);
		return r & ~(r - 8'h01);
	endfunction

endpackage

// *** rtl/rdc_i2c_slave.sv ***
// serial management slave: address match, register pointer, byte moves
// assumes scl and sda already synchronous to ref_clk_i, open-drain pins
`timescale 1ns/10ps

module rdc_i2c_slave
	import rdc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// serial pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oen_o,
	// register side
	input wire logic [7:0] rdata_i,
	output logic [6:0] sid_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_stb_o
);

	rdc_i2c_type st_ff;
	logic scl_ff;
	logic sda_ff;
	logic rw_ff;
	logic [7:0] sh_ff;
	logic [3:0] cnt_ff;

	wire scl_rise = scl_i & ~scl_ff;
	wire scl_fall = ~scl_i & scl_ff;
	wire start = scl_i & scl_ff & sda_ff & ~sda_i;
	wire stop = scl_i & scl_ff & ~sda_ff & sda_i;
	wire byte_done = (cnt_ff == 4'h8);
	wire id_hit = rdc_sid_ok(sh_ff[7:1]);

	// ------------------------------------------------------------
	// byte engine
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			st_ff <= I_IDLE;
			scl_ff <= 1'b1;
			sda_ff <= 1'b1;
			rw_ff <= 1'b0;
			sh_ff <= 8'h00;
			cnt_ff <= 4'h0;
			sda_o <= 1'b0;
			sda_oen_o <= 1'b1;
			sid_o <= 7'h00;
			addr_o <= 8'h00;
			wdata_o <= 8'h00;
			wr_stb_o <= 1'b0;
		end
		else
		begin
			scl_ff <= scl_i;
			sda_ff <= sda_i;
			wr_stb_o <= 1'b0;
			if (start)
			begin
				st_ff <= I_DEV;
				cnt_ff <= 4'h0;
				sda_oen_o <= 1'b1;
			end
			else if (stop)
			begin
				st_ff <= I_IDLE;
				sda_oen_o <= 1'b1;
			end
			else
			begin
				unique case (st_ff)
					I_IDLE:
						cnt_ff <= 4'h0;
					I_DEV, I_REG, I_WRD:
						if (scl_rise && !byte_done)
						begin
							sh_ff <= {sh_ff[6:0], sda_i};
							cnt_ff <= cnt_ff + 4'h1;
						end
						else if (scl_fall && byte_done)
						begin
							sda_oen_o <= 1'b0;
							if (st_ff == I_DEV)
							begin
								// foreign address: stay off the bus
								sda_oen_o <= !id_hit;
								sid_o <= sh_ff[7:1];
								rw_ff <= sh_ff[0];
								st_ff <= id_hit ? I_ADEV : I_IDLE; // [R12]
							end
							else if (st_ff == I_REG)
							begin
								addr_o <= sh_ff;
								st_ff <= I_AREG;
							end
							else
							begin
								wdata_o <= sh_ff;
								wr_stb_o <= 1'b1;
								st_ff <= I_AWR;
							end
						end
					I_ADEV, I_AREG, I_AWR:
						if (scl_fall)
						begin
							cnt_ff <= 4'h0;
							sda_oen_o <= 1'b1;
							if (st_ff == I_ADEV && rw_ff)
							begin
								sh_ff <= rdata_i;
								sda_oen_o <= rdata_i[7];
								st_ff <= I_RDD;
							end
							else
								st_ff <= (st_ff == I_ADEV) ? I_REG : I_WRD;
							if (st_ff == I_AWR)
								addr_o <= addr_o + 8'h01;
						end
					I_RDD:
						if (scl_fall)
						begin
							if (cnt_ff == 4'h7)
							begin
								sda_oen_o <= 1'b1;
								addr_o <= addr_o + 8'h01;
								st_ff <= I_RACK;
							end
							else
							begin
								sh_ff <= {sh_ff[6:0], 1'b0};
								sda_oen_o <= sh_ff[6];
								cnt_ff <= cnt_ff + 4'h1;
							end
						end
					I_RACK:
						if (scl_rise && sda_i)
							st_ff <= I_IDLE;
						else if (scl_fall)
						begin
							cnt_ff <= 4'h0;
							sh_ff <= rdata_i;
							sda_oen_o <= rdata_i[7];
							st_ff <= I_RDD;
						end
				endcase
			end
		end
	end

	a_id_ack: assert property ( // [R12]
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(st_ff == I_DEV && scl_fall && byte_done && !start && !stop)
		|=> ((st_ff == I_ADEV) == $past(id_hit)) &&
		(sda_oen_o == !$past(id_hit)))
		else $error("slave address acknowledge wrong");

endmodule

// *** rtl/rdc_reset_ctrl.sv ***
// reset domain controller: trigger priority, domain clears, power state,
// reset output and the reset related registers behind the serial slave
// assumes event inputs synchronous to ref_clk_i; rstn_i is power-on reset
// Functional notes
// [R1] power-on reset clears all four domains; reset output low meanwhile
// [R2] crystal failure clears all domains, reset low, wait-on or backup
// [R3] battery low keeps backup, clears the rest, reset high to low
// [R4] warm request clears config and charger only, stays active, reset low
// [R5] software reset clears all but backup, reset pulses low then high
// [R6] long key press clears all but backup, enters wait-on, reset low
// [R7] watchdog expiry clears all but backup, enters wait-on, reset low
// [R8] thermal shutdown clears all but backup, enters wait-on, reset low
// [R9] each register sits in one domain and clears only with it
// [R10] auto-clear bits drop to zero by themselves after a write
// [R11] flag bits read in one register, set and cleared through others
// [R12] answer at slave addresses 0x12, 0x48, 0x49 and 0x4A
`timescale 1ns/10ps

module rdc_reset_ctrl
	import rdc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// serial management pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oen_o,
	// reset triggers and start request
	input wire logic xtal_fail_i,
	input wire logic battery_low_minimum_i,
	input wire logic thermal_i,
	input wire logic wdt_expire_i,
	input wire logic long_key_i,
	input wire logic warm_reset_request_n_i,
	input wire logic start_req_i,
	// reset and power outputs
	output logic power_on_reset_out_n_o,
	output logic [3:0] domain_clr_o,
	output logic [1:0] pwr_state_o,
	// configuration and charger flag outputs
	output logic [6:0] wdt_cfg_o,
	output logic [7:0] kpd_cfg_o,
	output logic [7:0] charger_flag_o
);

	rdc_state_type st_ff;
	rdc_state_type nxt_st;
	logic [RDC_CNT_W-1:0] cnt_ff;
	logic [7:0] cause_ff;
	logic [7:0] devon_ff;
	logic [7:0] wdt_ff;
	logic [7:0] kpd_ff;
	logic kpd_sts_ff;
	logic [7:0] flag_ff;
	logic boot_ff;
	logic [6:0] sid;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr_stb;
	logic [7:0] rdata;

	// ------------------------------------------------------------
	// serial slave
	// ------------------------------------------------------------
	rdc_i2c_slave u_slave (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oen_o(sda_oen_o),
		.rdata_i(rdata),
		.sid_o(sid),
		.addr_o(addr),
		.wdata_o(wdata),
		.wr_stb_o(wr_stb)
	);

	// ------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------
	// only the first control slave holds these; the others read zero
	wire ctl = (sid == RDC_SID_CTL1);
	wire wr_ctl = wr_stb & ctl;
	wire wr_devon = wr_ctl & (addr == RDC_OFS_DEVON);
	wire wr_wdt = wr_ctl & (addr == RDC_OFS_WDT);
	wire wr_kpd = wr_ctl & (addr == RDC_OFS_KPD);
	wire wr_fset = wr_ctl & (addr == RDC_OFS_FLAG_SET);
	wire wr_fclr = wr_ctl & (addr == RDC_OFS_FLAG_CLR);

	wire [7:0] kpd_rd = (kpd_ff & RDC_KPD_MASK) |
		({7'h00, kpd_sts_ff} << RDC_KPD_STS_BIT);
	assign rdata = !ctl ? 8'h00 :
		(addr == RDC_OFS_TURNOFF) ? cause_ff :
		(addr == RDC_OFS_DEVON) ? devon_ff :
		(addr == RDC_OFS_PSTATE) ? {6'h00, pwr_state_o} :
		(addr == RDC_OFS_WDT) ? wdt_ff :
		(addr == RDC_OFS_KPD) ? kpd_rd :
		(addr == RDC_OFS_FLAG) ? flag_ff : 8'h00;

	// ------------------------------------------------------------
	// trigger priority and domain masks
	// ------------------------------------------------------------
	wire [7:0] req = {devon_ff[RDC_DEVICE_TURN_OFF_BIT_BIT], ~warm_reset_request_n_i,
		devon_ff[RDC_SWRST_BIT], long_key_i, wdt_expire_i, thermal_i,
		battery_low_minimum_i, xtal_fail_i};
	wire [7:0] hit = rdc_first(req);

	wire [3:0] clr = hit[RDC_EV_OSC] ? RDC_DOM_ALL : // [R2]
		(|hit[RDC_EV_SW:RDC_EV_BAT]) ? RDC_DOM_NOBCK : // [R3] [R5] [R6] [R7] [R8]
		hit[RDC_EV_WARM] ? RDC_DOM_WARM : RDC_DOM_NONE; // [R4]

	// turnoff cause: wdt, thermal, battery, long key, oscillator
	wire [7:0] cause_new = {3'h0, hit[RDC_EV_WDT], hit[RDC_EV_HOT],
		hit[RDC_EV_BAT], hit[RDC_EV_KEY], hit[RDC_EV_OSC]};
	wire turnoff = |cause_new;
	wire sw_done = (st_ff == ST_PULSE) && (cnt_ff == RDC_SW_LAST);
	wire goes_wait = hit[RDC_EV_HOT] | hit[RDC_EV_WDT] | hit[RDC_EV_KEY] |
		hit[RDC_EV_OFF];

	always_comb
	begin
		nxt_st = st_ff;
		if (hit[RDC_EV_OSC])
			nxt_st = battery_low_minimum_i ? ST_BACKUP : ST_WAIT; // [R2]
		else if (hit[RDC_EV_BAT])
			nxt_st = ST_BACKUP; // [R3]
		else if (goes_wait)
			nxt_st = ST_WAIT; // [R6] [R7] [R8]
		else if (hit[RDC_EV_SW])
			nxt_st = ST_PULSE; // [R5]
		else if (!hit[RDC_EV_WARM])
		begin
			unique case (st_ff)
				ST_ACTIVE: nxt_st = ST_ACTIVE;
				ST_PULSE: nxt_st = sw_done ? ST_ACTIVE : ST_PULSE;
				ST_WAIT: nxt_st = start_req_i ? ST_ACTIVE : ST_WAIT;
				ST_BACKUP: nxt_st = (start_req_i && !battery_low_minimum_i) ?
					ST_ACTIVE : ST_BACKUP;
			endcase
		end
	end

	// warm request holds the output low as long as it is asserted
	wire nxt_por = (nxt_st == ST_ACTIVE) && !hit[RDC_EV_WARM]; // [R4]
	wire [1:0] nxt_ps = (nxt_st == ST_BACKUP) ? RDC_PS_BACKUP :
		(nxt_st == ST_WAIT) ? RDC_PS_WAIT : RDC_PS_ACTIVE;
	wire [RDC_CNT_W-1:0] nxt_cnt = hit[RDC_EV_SW] ? '0 : cnt_ff + 1'b1;

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			st_ff <= ST_WAIT;
			cnt_ff <= '0;
			boot_ff <= 1'b1;
			power_on_reset_out_n_o <= 1'b0; // [R1]
			domain_clr_o <= RDC_DOM_ALL; // [R1]
			pwr_state_o <= RDC_PS_WAIT;
		end
		else
		begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			boot_ff <= 1'b0;
			power_on_reset_out_n_o <= nxt_por; // [R5]
			domain_clr_o <= clr;
			pwr_state_o <= nxt_ps;
		end
	end

	// ------------------------------------------------------------
	// domain registers
	// ------------------------------------------------------------
	// the async reset is the power-on trigger and clears every domain
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cause_ff <= RDC_RST_CAUSE;
			devon_ff <= 8'h00;
			wdt_ff <= RDC_RST_WDT;
			kpd_ff <= RDC_RST_KPD;
			kpd_sts_ff <= 1'b0;
			flag_ff <= RDC_RST_FLAG;
		end
		else
		begin
			kpd_sts_ff <= long_key_i;
			// backup domain: only a new cause or a full clear touches it
			if (turnoff)
				cause_ff <= cause_new; // [R9]
			else if (clr[RDC_DOM_BACKUP])
				cause_ff <= RDC_RST_CAUSE;
			// state domain; bits never hold past one cycle
			devon_ff <= (wr_devon && !clr[RDC_DOM_STATE]) ?
				(wdata & RDC_DEVON_MASK) : 8'h00; // [R10]
			if (clr[RDC_DOM_CONFIG])
			begin
				wdt_ff <= RDC_RST_WDT; // [R9]
				kpd_ff <= RDC_RST_KPD;
			end
			else
			begin
				if (wr_wdt)
					wdt_ff <= wdata & RDC_WDT_MASK;
				if (wr_kpd)
					kpd_ff <= wdata & RDC_KPD_MASK;
			end
			if (clr[RDC_DOM_CHG])
				flag_ff <= RDC_RST_FLAG; // [R9]
			else if (wr_fset)
				flag_ff <= flag_ff | wdata; // [R11]
			else if (wr_fclr)
				flag_ff <= flag_ff & ~wdata; // [R11]
		end
	end

	assign wdt_cfg_o = wdt_ff[6:0];
	assign kpd_cfg_o = kpd_ff;
	assign charger_flag_o = flag_ff;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_por_all: assert property ( // [R1]
		@(posedge ref_clk_i) disable iff (!rstn_i)
		boot_ff |-> (domain_clr_o == RDC_DOM_ALL) &&
		!power_on_reset_out_n_o && (cause_ff == RDC_RST_CAUSE))
		else $error("power-on state not fully cleared");

	a_osc_all: assert property ( // [R2]
		@(posedge ref_clk_i) disable iff (!rstn_i)
		hit[RDC_EV_OSC] |=> (domain_clr_o == RDC_DOM_ALL) &&
		!power_on_reset_out_n_o && (st_ff inside {ST_WAIT, ST_BACKUP}))
		else $error("crystal failure handling wrong");

	a_bat_keep: assert property ( // [R3]
		@(posedge ref_clk_i) disable iff (!rstn_i)
		hit[RDC_EV_BAT] |=> (domain_clr_o == RDC_DOM_NOBCK) &&
		(st_ff == ST_BACKUP) && !power_on_reset_out_n_o)
		else $error("battery low handling wrong");

	a_warm_mask: assert property ( // [R4]
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(hit[RDC_EV_WARM] && st_ff == ST_ACTIVE) |=>
		(domain_clr_o == RDC_DOM_WARM) && (st_ff == ST_ACTIVE) &&
		!power_on_reset_out_n_o)
		else $error("warm reset handling wrong");

	a_sw_low: assert property ( // [R5]
		@(posedge ref_clk_i) disable iff (!rstn_i)
		hit[RDC_EV_SW] |=> !power_on_reset_out_n_o && (cnt_ff == '0) &&
		(domain_clr_o == RDC_DOM_NOBCK) && (pwr_state_o == RDC_PS_ACTIVE))
		else $error("software reset did not start low");

	a_sw_high: assert property ( // [R5]
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(sw_done && hit == 8'h00) |-> !power_on_reset_out_n_o
		##1 power_on_reset_out_n_o)
		else $error("software reset did not return high");

	a_key_wait: assert property ( // [R6]
		@(posedge ref_clk_i) disable iff (!rstn_i)
		hit[RDC_EV_KEY] |=> (domain_clr_o == RDC_DOM_NOBCK) &&
		(pwr_state_o == RDC_PS_WAIT) && !power_on_reset_out_n_o)
		else $error("long key handling wrong");

	a_wdt_wait: assert property ( // [R7]
		@(posedge ref_clk_i) disable iff (!rstn_i)
		hit[RDC_EV_WDT] |=> (domain_clr_o == RDC_DOM_NOBCK) &&
		(st_ff == ST_WAIT) && cause_ff[4] && !power_on_reset_out_n_o)
		else $error("watchdog handling wrong");

	a_hot_wait: assert property ( // [R8]
		@(posedge ref_clk_i) disable iff (!rstn_i)
		hit[RDC_EV_HOT] |=> (domain_clr_o == RDC_DOM_NOBCK) &&
		(st_ff == ST_WAIT) && cause_ff[3] && !power_on_reset_out_n_o)
		else $error("thermal shutdown handling wrong");

	a_backup_hold: assert property ( // [R9]
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(!turnoff && !clr[RDC_DOM_BACKUP]) |=> $stable(cause_ff))
		else $error("backup register changed without trigger");

	a_auto_clear: assert property ( // [R10]
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(wr_devon ##1 !wr_devon) |=> (devon_ff == 8'h00))
		else $error("auto-clear bit did not drop");

	a_flag_set: assert property ( // [R11]
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(wr_fset && !clr[RDC_DOM_CHG]) |=>
		((flag_ff & $past(wdata)) == $past(wdata)))
		else $error("flag set register had no effect");

endmodule

// *** sim/rdc_host_model.sv ***
// host model: bit-level master of the serial management bus
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/10ps

module rdc_host_model
(
	// clock
	input wire logic ref_clk_i,
	// serial pins
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	// ------------------------------------------------------------
	// bit and frame primitives
	// ------------------------------------------------------------
	// four clocks a phase: well above the two-clock minimum
	task automatic half();
		repeat (4) @(negedge ref_clk_i);
	endtask

	// data moves one clock after scl falls, never with it
	task automatic bit_out(input logic b);
		@(negedge ref_clk_i);
		sda_low_o = ~b;
		half();
		scl_o = 1'b1;
		half();
		scl_o = 1'b0;
	endtask

	task automatic start();
		@(negedge ref_clk_i);
		sda_low_o = 1'b0;
		half();
		scl_o = 1'b1;
		half();
		sda_low_o = 1'b1;
		half();
		scl_o = 1'b0;
	endtask

	task automatic stop();
		@(negedge ref_clk_i);
		sda_low_o = 1'b1;
		half();
		scl_o = 1'b1;
		half();
		sda_low_o = 1'b0;
		half();
	endtask

	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_out(b[i]);
		@(negedge ref_clk_i);
		sda_low_o = 1'b0;
		half();
		scl_o = 1'b1;
		half();
		ack = ~sda_i;
		scl_o = 1'b0;
	endtask

	// single byte reads only, so the host always ends with a nack
	task automatic recv(output logic [7:0] b);
		for (int i = 7; i >= 0; i--)
		begin
			half();
			scl_o = 1'b1;
			half();
			b[i] = sda_i;
			scl_o = 1'b0;
		end
		bit_out(1'b1);
	endtask

	// ------------------------------------------------------------
	// register transfers
	// ------------------------------------------------------------
	task automatic write_reg(input logic [6:0] sid, input logic [7:0] ofs,
		input logic [7:0] dat, output logic ack);
		logic a0;
		logic a1;
		logic a2;
		start();
		send({sid, 1'b0}, a0);
		send(ofs, a1);
		send(dat, a2);
		stop();
		ack = a0 & a1 & a2;
	endtask

	task automatic read_reg(input logic [6:0] sid, input logic [7:0] ofs,
		output logic [7:0] dat, output logic ack);
		logic a0;
		logic a1;
		logic a2;
		start();
		send({sid, 1'b0}, a0);
		send(ofs, a1);
		start();
		send({sid, 1'b1}, a2);
		recv(dat);
		stop();
		ack = a0 & a1 & a2;
	endtask
endmodule

// *** sim/tb_top.sv ***
// testbench: reset triggers, domain clears and registers over the bus
// assumes rdc_pkg compiled first and the host model beside it
`timescale 1ns/10ps

module tb_top
	import rdc_pkg::*;
;
	logic ref_clk;
	logic rstn;
	logic scl;
	logic host_low;
	logic sda_w;
	logic sda_drv;
	logic sda_oen;
	logic [4:0] trig;
	logic warm_n;
	logic start_req;
	logic por_n;
	logic [3:0] dom_clr;
	logic [1:0] pstate;
	logic [6:0] wdt_cfg;
	logic [7:0] kpd_cfg;
	logic [7:0] flag;
	logic ack;
	logic [7:0] rd;
	logic [3:0] last_clr;
	logic [6:0] sids [5];
	int pulse_cnt;
	int low_cnt;
	int err_total;
	int checks;

	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// pull-up on the wire; either side may pull low
	assign sda_w = host_low ? 1'b0 : (sda_oen ? 1'b1 : sda_drv);

	rdc_reset_ctrl DUT (
		.ref_clk_i(ref_clk),
		.rstn_i(rstn),
		.scl_i(scl),
		.sda_i(sda_w),
		.sda_o(sda_drv),
		.sda_oen_o(sda_oen),
		.xtal_fail_i(trig[4]),
		.battery_low_minimum_i(trig[3]),
		.thermal_i(trig[2]),
		.wdt_expire_i(trig[1]),
		.long_key_i(trig[0]),
		.warm_reset_request_n_i(warm_n),
		.start_req_i(start_req),
		.power_on_reset_out_n_o(por_n),
		.domain_clr_o(dom_clr),
		.pwr_state_o(pstate),
		.wdt_cfg_o(wdt_cfg),
		.kpd_cfg_o(kpd_cfg),
		.charger_flag_o(flag)
	);

	rdc_host_model host (
		.ref_clk_i(ref_clk),
		.sda_i(sda_w),
		.scl_o(scl),
		.sda_low_o(host_low)
	);

	// ------------------------------------------------------------
	// monitor and helpers
	// ------------------------------------------------------------
	// sampled after the edge so the main sequence never races it
	always @(posedge ref_clk)
	begin
		#5;
		if (dom_clr !== 4'h0)
		begin
			last_clr = dom_clr;
			pulse_cnt++;
		end
		if (por_n === 1'b0)
			low_cnt++;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected %0t ns: %s got %h want %h", $time, what,
				got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] ofs, input logic [7:0] dat);
		host.write_reg(RDC_SID_CTL1, ofs, dat, ack);
		chk({7'h00, ack}, 8'h01, "write ack");
	endtask

	task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp,
		input string what);
		host.read_reg(RDC_SID_CTL1, ofs, rd, ack);
		chk({7'h00, ack}, 8'h01, "read ack");
		chk(rd, exp, what);
	endtask

	task automatic power_up();
		@(negedge ref_clk);
		start_req = 1'b1;
		@(negedge ref_clk);
		start_req = 1'b0;
		repeat (2) @(negedge ref_clk);
		chk({7'h00, por_n}, 8'h01, "reset out released");
		chk({6'h00, pstate}, {6'h00, RDC_PS_ACTIVE}, "active");
		wr(RDC_OFS_WDT, 8'h55);
		wr(RDC_OFS_FLAG_SET, 8'h01);
		pulse_cnt = 0;
		low_cnt = 0;
	endtask

	// one-cycle trigger, then domains, state, output and cause
	task automatic fire(input logic [4:0] t, input logic [3:0] exp_clr,
		input logic [1:0] exp_st, input logic [7:0] exp_cause);
		power_up();
		trig = t;
		@(negedge ref_clk);
		trig = 5'h00;
		repeat (3) @(negedge ref_clk);
		chk(8'(pulse_cnt), 8'h01, "one clear pulse");
		chk({4'h0, last_clr}, {4'h0, exp_clr}, "cleared domains");
		chk({7'h00, por_n}, 8'h00, "reset out low");
		chk({6'h00, pstate}, {6'h00, exp_st}, "power state");
		chk({1'b0, wdt_cfg}, 8'h00, "config domain");
		chk(kpd_cfg, 8'h00, "kpd domain");
		chk(flag, 8'h00, "charger domain");
		rd_chk(RDC_OFS_TURNOFF, exp_cause, "turn-off cause");
		$display("test trigger %b done", t);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		rstn = 1'b0;
		trig = 5'h00;
		warm_n = 1'b1;
		start_req = 1'b0;
		err_total = 0;
		checks = 0;
		pulse_cnt = 0;
		low_cnt = 0;
		last_clr = 4'h0;
		sids = '{RDC_SID_VSCALE, RDC_SID_CTL2, RDC_SID_CTL3, RDC_SID_CTL1,
			7'h30};
		repeat (5) @(negedge ref_clk);
		chk({4'h0, dom_clr}, {4'h0, RDC_DOM_ALL}, "clear in reset");
		chk({7'h00, por_n}, 8'h00, "reset out in reset");
		chk({7'h00, sda_oen}, 8'h01, "sda released");
		rstn = 1'b1;
		@(negedge ref_clk);
		chk({6'h00, pstate}, {6'h00, RDC_PS_WAIT}, "wait-on");
		rd_chk(RDC_OFS_WDT, RDC_RST_WDT, "wdt reset");
		rd_chk(RDC_OFS_KPD, RDC_RST_KPD, "kpd reset");
		rd_chk(RDC_OFS_TURNOFF, RDC_RST_CAUSE, "cause reset");
		rd_chk(RDC_OFS_FLAG, RDC_RST_FLAG, "flag reset");
		$display("test reset done");

		wr(RDC_OFS_WDT, 8'hFF);
		rd_chk(RDC_OFS_WDT, RDC_WDT_MASK, "wdt write");
		wr(RDC_OFS_KPD, 8'hFF);
		rd_chk(RDC_OFS_KPD, RDC_KPD_MASK, "kpd write");
		chk(kpd_cfg, RDC_KPD_MASK, "kpd port");
		wr(RDC_OFS_TURNOFF, 8'hFF);
		rd_chk(RDC_OFS_TURNOFF, 8'h00, "read-only cause");
		wr(RDC_OFS_FLAG_SET, 8'h81);
		rd_chk(RDC_OFS_FLAG, 8'h81, "flag set");
		wr(RDC_OFS_FLAG_CLR, 8'h01);
		rd_chk(RDC_OFS_FLAG, 8'h80, "flag clear");
		chk(flag, 8'h80, "flag port");
		$display("test registers done");

		for (int i = 0; i < 5; i++)
		begin
			host.write_reg(sids[i], RDC_OFS_WDT, 8'h11, ack);
			chk({7'h00, ack}, {7'h00, i < 4}, "address ack");
			chk({1'b0, wdt_cfg}, (i < 3) ? 8'h7F : 8'h11, "landing");
		end
		host.read_reg(RDC_SID_CTL2, RDC_OFS_WDT, rd, ack);
		chk(rd, 8'h00, "empty slave read");
		$display("test addresses done");

		fire(5'b00100, RDC_DOM_NOBCK, RDC_PS_WAIT, 8'h08);
		fire(5'b00010, RDC_DOM_NOBCK, RDC_PS_WAIT, 8'h10);
		fire(5'b00001, RDC_DOM_NOBCK, RDC_PS_WAIT, 8'h02);
		fire(5'b00011, RDC_DOM_NOBCK, RDC_PS_WAIT, 8'h10);
		fire(5'b01000, RDC_DOM_NOBCK, RDC_PS_BACKUP, 8'h04);
		fire(5'b10000, RDC_DOM_ALL, RDC_PS_WAIT, 8'h01);
		fire(5'b11000, RDC_DOM_ALL, RDC_PS_BACKUP, 8'h01);

		power_up();
		warm_n = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk({7'h00, por_n}, 8'h00, "low while warm held");
		warm_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		chk(8'(pulse_cnt), 8'h03, "pulse per cycle held");
		chk({4'h0, last_clr}, {4'h0, RDC_DOM_WARM}, "warm domains");
		chk({6'h00, pstate}, {6'h00, RDC_PS_ACTIVE}, "stays active");
		chk({7'h00, por_n}, 8'h01, "released after warm");
		chk({1'b0, wdt_cfg}, 8'h00, "config cleared");
		chk(flag, 8'h00, "warm charger cleared");
		rd_chk(RDC_OFS_TURNOFF, 8'h01, "backup kept");
		$display("test warm done");

		power_up();
		wr(RDC_OFS_DEVON, 8'h40);
		repeat (60) @(negedge ref_clk);
		chk(8'(pulse_cnt), 8'h01, "sw clear pulse");
		chk({4'h0, last_clr}, {4'h0, RDC_DOM_NOBCK}, "sw domains");
		chk(8'(low_cnt), 8'(RDC_SWRST_CYC), "sw low time");
		chk({7'h00, por_n}, 8'h01, "high again");
		chk({6'h00, pstate}, {6'h00, RDC_PS_ACTIVE}, "sw active");
		chk({1'b0, wdt_cfg}, 8'h00, "sw config cleared");
		rd_chk(RDC_OFS_DEVON, 8'h00, "auto-clear bit");
		$display("test software reset done");

		power_up();
		wr(RDC_OFS_DEVON, 8'h01);
		chk({6'h00, pstate}, {6'h00, RDC_PS_WAIT}, "turn-off state");
		chk(8'(pulse_cnt), 8'h00, "no clear on turn-off");
		chk({1'b0, wdt_cfg}, 8'h55, "config kept");
		rd_chk(RDC_OFS_TURNOFF, 8'h01, "cause kept");
		$display("test turn-off done");

		rstn = 1'b0;
		@(negedge ref_clk);
		rstn = 1'b1;
		@(negedge ref_clk);
		rd_chk(RDC_OFS_TURNOFF, RDC_RST_CAUSE, "backup on power-on");
		$display("test second reset done");
		end_sim();
	end

	// hang guard, under 100k clock cycles
	initial
	begin
		#3800000;
		err_total++;
		$display("unexpected %0t ns: run timed out", $time);
		end_sim();
	end
endmodule
